/* File: shared/prs_pkg.sv */
// Constants for the policer and router-leg statistics counters.
// Assumes a 32-bit APB slave with 12-bit byte addresses.
package prs_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int CNT_W = 40;
	localparam int LOW_W = 32;
	localparam int HIGH_W = 8;
	localparam int LEN_W = 14;
	localparam int NUM_BCAST = 64;
	localparam int NUM_ACL = 64;
	localparam int PIDX_W = 6;
	localparam int NUM_LEGS = 128;
	localparam int LEG_W = 7;
	localparam int NUM_IPV = 2;
	localparam int LEG_CTRS = 8;
	localparam int POL_CTRS = 2;
	localparam int BCAST_EV = 6;
	localparam int ACL_EV = 8;
	localparam int IR_EV = 7;
	localparam int ER_EV = 5;
	localparam logic [7:0] TTL_MIN = 8'h02;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] SEL_OFF = 12'h000;
	localparam logic [11:0] LOW_OFF = 12'h004;
	localparam logic [11:0] HIGH_OFF = 12'h008;
	localparam logic [11:0] BCAST_CFG_OFF = 12'h010;
	localparam logic [11:0] ACL_CFG_OFF = 12'h014;
	localparam logic [11:0] IR_CFG_OFF = 12'h018;
	localparam logic [11:0] ER_CFG_OFF = 12'h01c;
	localparam logic [11:0] BCAST_MASK_OFF = 12'h020;
	localparam logic [11:0] ACL_MASK_OFF = 12'h028;
	localparam logic [11:0] IR_MASK_OFF = 12'h040;
	localparam logic [11:0] ER_MASK_OFF = 12'h060;
	localparam logic [11:0] TTL_OFF = 12'h400;
	localparam logic [11:0] TTL_END = 12'h5fc;
	// Selector register fields
	localparam int SEL_CTR_LSB = 0;
	localparam int SEL_IDX_LSB = 3;
	localparam int SEL_GRP_LSB = 12;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PRS_GRP_BCAST,
		PRS_GRP_ACL,
		PRS_GRP_IR,
		PRS_GRP_ER
	} prs_grp_t;
	typedef enum logic [1:0] {
		PRS_BCAST,
		PRS_MCAST,
		PRS_UCAST
	} prs_kind_t;
endpackage : prs_pkg

/* File: rtl/prs_stat_counters.sv */
// Statistics counter sets for policers and router legs, with APB access.
// Assumes event strobes come from logic on pclk, one frame per group per cycle.
//
// Behaviour
// R1 - Two counters per broadcast policer index
// R2 - Broadcast settings global for all sets
// R3 - Six broadcast events: discarded or passed
// R4 - Counters 40 bits: low 32, high 8
// R5 - Low read latches high part to shadow
// R6 - Software reads low then high
// R7 - Software writes high then low
// R8 - Two ACL counter types, global settings
// R9 - Inner flag marks ACL policer inner
// R10 - Eight ACL events: source, verdict, stage
// R11 - Ingress leg counters: 128 legs, 2 versions
// R12 - Ingress counter types byte/frame configurable
// R13 - Egress counter types byte/frame configurable
// R14 - Ingress events: received and routed frames
// R15 - Classifier drop without route enable counts
// R16 - Reverse-path failure raises ingress event
// R17 - Time-to-live below two raises ingress event
// R18 - Egress events: routed and bridged multicast
// R19 - Time-to-live below leg threshold, egress event
// R20 - One ingress mask per counter type
// R21 - One egress mask per counter type
// R22 - Mask bit i enables event i
// R23 - Add length or one, wrap
// R24 - Low write loads full counter atomically
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module prs_stat_counters import prs_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bcast_valid,
	input wire logic [PIDX_W-1:0] bcast_index,
	input wire logic [LEN_W-1:0] bcast_len,
	input wire logic [1:0] bcast_kind,
	input wire logic bcast_discard,
	input wire logic acl_valid,
	input wire logic [PIDX_W-1:0] acl_index,
	input wire logic [LEN_W-1:0] acl_len,
	input wire logic acl_cpu_src,
	input wire logic acl_discard,
	input wire logic inner_policer_flag,
	input wire logic ir_valid,
	input wire logic [LEG_W-1:0] ir_leg,
	input wire logic ir_ipv6,
	input wire logic [LEN_W-1:0] ir_len,
	input wire logic ir_classifier_drop,
	input wire logic ir_route_enable_action,
	input wire logic ir_ip_ucast,
	input wire logic ir_ip_mcast,
	input wire logic ir_ucast_routed,
	input wire logic ir_mcast_routed,
	input wire logic ir_rpf_fail,
	input wire logic [7:0] ir_ttl,
	input wire logic er_valid,
	input wire logic [LEG_W-1:0] er_leg,
	input wire logic er_ipv6,
	input wire logic [LEN_W-1:0] er_len,
	input wire logic er_classifier_drop,
	input wire logic er_route_enable_action,
	input wire logic er_ucast_routed,
	input wire logic er_mcast_routed,
	input wire logic er_mcast_bridged,
	input wire logic er_mcast,
	input wire logic [7:0] er_ttl
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [CNT_W-1:0] step(input logic byte_mode, input logic [LEN_W-1:0] len);
		step = byte_mode ? CNT_W'(len) : CNT_W'(1);
	endfunction : step

	function automatic logic hit(input logic [7:0] mask, input logic [7:0] ev);
		hit = |(mask & ev);
	endfunction : hit

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [HIGH_W-1:0] shadow;
		logic [HIGH_W-1:0] high_wr;
		logic [15:0] sel;
		logic [POL_CTRS-1:0] bcast_byte;
		logic [POL_CTRS-1:0] acl_byte;
		logic [LEG_CTRS-1:0] ir_byte;
		logic [LEG_CTRS-1:0] er_byte;
		logic [POL_CTRS-1:0][BCAST_EV-1:0] bcast_mask;
		logic [POL_CTRS-1:0][ACL_EV-1:0] acl_mask;
		logic [LEG_CTRS-1:0][IR_EV-1:0] ir_mask;
		logic [LEG_CTRS-1:0][ER_EV-1:0] er_mask;
	} prs_state_t;

	prs_state_t st_reg;
	prs_state_t st_next;

	// Counters live in plain arrays; they have no reset, software clears them
	logic [CNT_W-1:0] bcast_mem [NUM_BCAST][POL_CTRS];
	logic [CNT_W-1:0] acl_mem [NUM_ACL][POL_CTRS];
	logic [CNT_W-1:0] ir_mem [NUM_LEGS*NUM_IPV][LEG_CTRS];
	logic [CNT_W-1:0] er_mem [NUM_LEGS*NUM_IPV][LEG_CTRS];
	logic [7:0] ttl_mem [NUM_LEGS];

	// ----------------------------------------------------------------
	// Event vectors
	// ----------------------------------------------------------------
	logic [BCAST_EV-1:0] bcast_ev;
	logic [ACL_EV-1:0] acl_ev;
	logic [IR_EV-1:0] ir_ev;
	logic [ER_EV-1:0] er_ev;
	logic [2:0] bcast_bit;
	always_comb begin
		bcast_bit = bcast_discard ? {1'b0, bcast_kind} : 3'({1'b0, bcast_kind} + 3'h3);
		bcast_ev = '0;
		if (bcast_kind != 2'h3) begin
			bcast_ev[bcast_bit] = 1'b1; // R3
		end
		acl_ev = 8'h01 << {inner_policer_flag, acl_discard, ~acl_cpu_src}; // R9 R10
		ir_ev[0] = ir_classifier_drop & ~ir_route_enable_action; // R15
		ir_ev[1] = ir_ip_ucast; // R14
		ir_ev[2] = ir_ip_mcast; // R14
		ir_ev[3] = ir_ucast_routed; // R14
		ir_ev[4] = ir_mcast_routed; // R14
		ir_ev[5] = ir_rpf_fail; // R16
		// Only IP frames carry a meaningful time-to-live
		ir_ev[6] = (ir_ip_ucast | ir_ip_mcast) & (ir_ttl < TTL_MIN); // R17
		er_ev[0] = er_classifier_drop & ~er_route_enable_action; // R15
		er_ev[1] = er_ucast_routed; // R18
		er_ev[2] = er_mcast_routed; // R18
		er_ev[3] = er_mcast_bridged; // R18
		er_ev[4] = er_mcast & (er_ttl < ttl_mem[er_leg]); // R19
	end

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	logic acc;
	logic done;
	logic wr_done;
	logic is_ttl;
	logic [1:0] grp;
	logic [7:0] sel_idx;
	logic [2:0] sel_ctr;
	logic [7:0] ir_ent;
	logic [7:0] er_ent;
	logic [CNT_W-1:0] cnt_sel;
	logic [CNT_W-1:0] load_val;
	logic wr_low;
	assign acc = psel & penable;
	assign done = acc & st_reg.pready;
	assign wr_done = done & pwrite;
	// Threshold table decodes by range, so its words need no case items
	assign is_ttl = (paddr >= TTL_OFF) && (paddr <= TTL_END);
	assign grp = st_reg.sel[SEL_GRP_LSB +: 2];
	assign sel_idx = st_reg.sel[SEL_IDX_LSB +: 8];
	assign sel_ctr = st_reg.sel[SEL_CTR_LSB +: 3];
	assign ir_ent = {ir_leg, ir_ipv6};
	assign er_ent = {er_leg, er_ipv6};
	assign wr_low = wr_done && (paddr == LOW_OFF);
	assign load_val = {st_reg.high_wr, pwdata}; // R24

	// Policer groups ignore the upper selector bits they do not need
	always_comb begin
		unique case (grp)
			PRS_GRP_BCAST: cnt_sel = bcast_mem[sel_idx[PIDX_W-1:0]][sel_ctr[0]];
			PRS_GRP_ACL: cnt_sel = acl_mem[sel_idx[PIDX_W-1:0]][sel_ctr[0]];
			PRS_GRP_IR: cnt_sel = ir_mem[sel_idx][sel_ctr];
			PRS_GRP_ER: cnt_sel = er_mem[sel_idx][sel_ctr];
		endcase
	end

	logic [31:0] rd_val;
	logic mapped;
	always_comb begin
		rd_val = '0;
		mapped = 1'b1;
		if (is_ttl) begin
			rd_val = {24'h0, ttl_mem[paddr[8:2]]};
		end else begin
			unique case (paddr)
				SEL_OFF: rd_val = {16'h0, st_reg.sel};
				LOW_OFF: rd_val = cnt_sel[LOW_W-1:0]; // R4
				HIGH_OFF: rd_val = {24'h0, st_reg.shadow}; // R5
				BCAST_CFG_OFF: rd_val = {30'h0, st_reg.bcast_byte};
				ACL_CFG_OFF: rd_val = {30'h0, st_reg.acl_byte};
				IR_CFG_OFF: rd_val = {24'h0, st_reg.ir_byte};
				ER_CFG_OFF: rd_val = {24'h0, st_reg.er_byte};
				BCAST_MASK_OFF: rd_val = {26'h0, st_reg.bcast_mask[0]};
				BCAST_MASK_OFF + 12'h004: rd_val = {26'h0, st_reg.bcast_mask[1]};
				ACL_MASK_OFF: rd_val = {24'h0, st_reg.acl_mask[0]};
				ACL_MASK_OFF + 12'h004: rd_val = {24'h0, st_reg.acl_mask[1]};
				default: begin
					if (paddr[11:5] == IR_MASK_OFF[11:5]) begin
						rd_val = {25'h0, st_reg.ir_mask[paddr[4:2]]};
					end else if (paddr[11:5] == ER_MASK_OFF[11:5]) begin
						rd_val = {27'h0, st_reg.er_mask[paddr[4:2]]};
					end else begin
						mapped = 1'b0;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Control state
	// ----------------------------------------------------------------
	// One wait state: the answer is registered so every bus output is a flop
	always_comb begin
		st_next = st_reg;
		st_next.pready = acc & ~st_reg.pready;
		st_next.pslverr = acc & ~st_reg.pready & ~mapped;
		if (acc && !st_reg.pready) begin
			st_next.prdata = pwrite ? 32'h0 : rd_val;
			// Shadow taken with the low word so both halves match
			if (!pwrite && paddr == LOW_OFF) begin
				st_next.shadow = cnt_sel[CNT_W-1:LOW_W]; // R5
			end
		end
		if (wr_done && !is_ttl) begin
			unique case (paddr)
				SEL_OFF: st_next.sel = pwdata[15:0];
				HIGH_OFF: st_next.high_wr = pwdata[HIGH_W-1:0]; // R24
				BCAST_CFG_OFF: st_next.bcast_byte = pwdata[1:0]; // R2
				ACL_CFG_OFF: st_next.acl_byte = pwdata[1:0]; // R8
				IR_CFG_OFF: st_next.ir_byte = pwdata[7:0]; // R12
				ER_CFG_OFF: st_next.er_byte = pwdata[7:0]; // R13
				BCAST_MASK_OFF: st_next.bcast_mask[0] = pwdata[BCAST_EV-1:0]; // R2
				BCAST_MASK_OFF + 12'h004: st_next.bcast_mask[1] = pwdata[BCAST_EV-1:0];
				ACL_MASK_OFF: st_next.acl_mask[0] = pwdata[ACL_EV-1:0]; // R8
				ACL_MASK_OFF + 12'h004: st_next.acl_mask[1] = pwdata[ACL_EV-1:0];
				default: begin
					if (paddr[11:5] == IR_MASK_OFF[11:5]) begin
						st_next.ir_mask[paddr[4:2]] = pwdata[IR_EV-1:0]; // R20
					end else if (paddr[11:5] == ER_MASK_OFF[11:5]) begin
						st_next.er_mask[paddr[4:2]] = pwdata[ER_EV-1:0]; // R21
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;

	// ----------------------------------------------------------------
	// Counter arrays
	// ----------------------------------------------------------------
	// A software load is written last so it wins over a same-cycle count
	always_ff @(posedge pclk) begin
		for (int c = 0; c < POL_CTRS; c++) begin
			if (bcast_valid && hit(8'(st_reg.bcast_mask[c]), 8'(bcast_ev))) begin // R1 R22
				bcast_mem[bcast_index][c] <= bcast_mem[bcast_index][c]
					+ step(st_reg.bcast_byte[c], bcast_len); // R23
			end
			if (acl_valid && hit(st_reg.acl_mask[c], acl_ev)) begin // R8 R22
				acl_mem[acl_index][c] <= acl_mem[acl_index][c] + step(st_reg.acl_byte[c], acl_len); // R23
			end
		end
		for (int c = 0; c < LEG_CTRS; c++) begin
			if (ir_valid && hit(8'(st_reg.ir_mask[c]), 8'(ir_ev))) begin // R11 R20
				ir_mem[ir_ent][c] <= ir_mem[ir_ent][c] + step(st_reg.ir_byte[c], ir_len); // R23
			end
			if (er_valid && hit(8'(st_reg.er_mask[c]), 8'(er_ev))) begin // R21
				er_mem[er_ent][c] <= er_mem[er_ent][c] + step(st_reg.er_byte[c], er_len); // R23
			end
		end
		if (wr_low) begin
			unique case (grp)
				PRS_GRP_BCAST: bcast_mem[sel_idx[PIDX_W-1:0]][sel_ctr[0]] <= load_val; // R24
				PRS_GRP_ACL: acl_mem[sel_idx[PIDX_W-1:0]][sel_ctr[0]] <= load_val; // R24
				PRS_GRP_IR: ir_mem[sel_idx][sel_ctr] <= load_val; // R24
				PRS_GRP_ER: er_mem[sel_idx][sel_ctr] <= load_val; // R24
			endcase
		end
		if (wr_done && is_ttl) begin
			ttl_mem[paddr[8:2]] <= pwdata[7:0]; // R19
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Model of the one counter software has selected, for the checks below
	logic sel_hit;
	logic [CNT_W-1:0] sel_inc;
	always_comb begin
		sel_hit = 1'b0;
		sel_inc = '0;
		unique case (grp)
			PRS_GRP_BCAST: begin
				sel_hit = bcast_valid && bcast_index == sel_idx[PIDX_W-1:0]
					&& hit(8'(st_reg.bcast_mask[sel_ctr[0]]), 8'(bcast_ev));
				sel_inc = step(st_reg.bcast_byte[sel_ctr[0]], bcast_len);
			end
			PRS_GRP_ACL: begin
				sel_hit = acl_valid && acl_index == sel_idx[PIDX_W-1:0]
					&& hit(st_reg.acl_mask[sel_ctr[0]], acl_ev);
				sel_inc = step(st_reg.acl_byte[sel_ctr[0]], acl_len);
			end
			PRS_GRP_IR: begin
				sel_hit = ir_valid && ir_ent == sel_idx
					&& hit(8'(st_reg.ir_mask[sel_ctr]), 8'(ir_ev));
				sel_inc = step(st_reg.ir_byte[sel_ctr], ir_len);
			end
			PRS_GRP_ER: begin
				sel_hit = er_valid && er_ent == sel_idx
					&& hit(8'(st_reg.er_mask[sel_ctr]), 8'(er_ev));
				sel_inc = step(st_reg.er_byte[sel_ctr], er_len);
			end
		endcase
	end

	a_count_step: assert property (@(posedge pclk) disable iff (!presetn) // R23
		sel_hit && !wr_done |=> cnt_sel == $past(cnt_sel) + $past(sel_inc))
		else $error("selected counter did not advance by its step");
	a_low_load: assert property (@(posedge pclk) disable iff (!presetn) // R24
		wr_low |=> cnt_sel == {$past(st_reg.high_wr), $past(pwdata)})
		else $error("low write did not load the full counter");
	a_shadow_latch: assert property (@(posedge pclk) disable iff (!presetn) // R5
		acc && !st_reg.pready && !pwrite && paddr == LOW_OFF
		|=> st_reg.shadow == $past(cnt_sel[CNT_W-1:LOW_W]) && prdata == $past(cnt_sel[LOW_W-1:0]))
		else $error("shadow and low word do not match one counter value");
	a_high_read: assert property (@(posedge pclk) disable iff (!presetn) // R4
		acc && !st_reg.pready && !pwrite && paddr == HIGH_OFF
		|=> prdata == {24'h0, $past(st_reg.shadow)})
		else $error("high read did not return the shadow");
	a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		acc && !pready |=> pready ##1 !pready)
		else $error("answer not one wait state, one cycle long");
	a_inner_acl: assert property (@(posedge pclk) disable iff (!presetn) // R9
		acl_valid && inner_policer_flag |-> acl_ev[7:4] != 4'h0 && acl_ev[3:0] == 4'h0)
		else $error("inner policer event in outer half");
	a_drop_event: assert property (@(posedge pclk) disable iff (!presetn) // R15
		ir_ev[0] == (ir_classifier_drop && !ir_route_enable_action)
		&& er_ev[0] == (er_classifier_drop && !er_route_enable_action))
		else $error("classifier drop event wrong");
	a_ttl_ingress: assert property (@(posedge pclk) disable iff (!presetn) // R17
		ir_ip_ucast && ir_ttl < TTL_MIN |-> ir_ev[6])
		else $error("low time-to-live not flagged");
	a_ttl_egress: assert property (@(posedge pclk) disable iff (!presetn) // R19
		er_mcast && er_ttl >= ttl_mem[er_leg] |-> !er_ev[4])
		else $error("egress time-to-live event above threshold");
	a_frame_step: assert property (@(posedge pclk) disable iff (!presetn) // R12
		grp == PRS_GRP_IR && sel_hit && !wr_done && !st_reg.ir_byte[sel_ctr]
		|=> cnt_sel == $past(cnt_sel) + CNT_W'(1))
		else $error("frame mode step is not one");
	a_bcast_onehot: assert property (@(posedge pclk) disable iff (!presetn) // R3
		bcast_valid && bcast_kind != 2'h3 |-> $onehot(bcast_ev))
		else $error("broadcast policer event not exactly one");
	a_acl_onehot: assert property (@(posedge pclk) disable iff (!presetn) // R10
		acl_valid |-> $onehot(acl_ev))
		else $error("access-list policer event not exactly one");
	a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		acc && !st_reg.pready && !mapped |=> pready && pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
endmodule : prs_stat_counters

/* File: tb/prs_stat_counters_bench.sv */
// Self-checking bench for the policer and router-leg statistics counters.
// Assumes the package constants and an APB slave that answers on its own time.
`timescale 1ns/1ns
module prs_stat_counters_bench import prs_pkg::*;;
	// ----------------------------------------------------------------
	// Stimulus signals
	// ----------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, rerr;
	logic bcast_valid = 0, bcast_discard = 0, acl_valid = 0, acl_cpu_src = 0, acl_discard = 0;
	logic inner_policer_flag = 0, ir_valid = 0, ir_ipv6 = 0, ir_classifier_drop = 0;
	logic ir_route_enable_action = 0, ir_ip_ucast = 0, ir_ip_mcast = 0, ir_ucast_routed = 0;
	logic ir_mcast_routed = 0, ir_rpf_fail = 0, er_valid = 0, er_ipv6 = 0, er_mcast = 0;
	logic er_classifier_drop = 0, er_route_enable_action = 0, er_ucast_routed = 0;
	logic er_mcast_routed = 0, er_mcast_bridged = 0;
	logic [1:0] bcast_kind = 2'h0;
	logic [PIDX_W-1:0] bcast_index = '0, acl_index = '0;
	logic [LEG_W-1:0] ir_leg = '0, er_leg = '0;
	logic [LEN_W-1:0] bcast_len = '0, acl_len = '0, ir_len = '0, er_len = '0;
	logic [7:0] ir_ttl = 8'h00, er_ttl = 8'h00;
	int fails = 0;
	int check_count = 0;

	prs_stat_counters i_prs_stat_counters (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bcast_valid(bcast_valid),
		.bcast_index(bcast_index), .bcast_len(bcast_len), .bcast_kind(bcast_kind),
		.bcast_discard(bcast_discard),
		.acl_valid(acl_valid), .acl_index(acl_index), .acl_len(acl_len),
		.acl_cpu_src(acl_cpu_src), .acl_discard(acl_discard),
		.inner_policer_flag(inner_policer_flag), .ir_valid(ir_valid), .ir_leg(ir_leg),
		.ir_ipv6(ir_ipv6), .ir_len(ir_len), .ir_classifier_drop(ir_classifier_drop),
		.ir_route_enable_action(ir_route_enable_action), .ir_ip_ucast(ir_ip_ucast),
		.ir_ip_mcast(ir_ip_mcast), .ir_ucast_routed(ir_ucast_routed),
		.ir_mcast_routed(ir_mcast_routed), .ir_rpf_fail(ir_rpf_fail), .ir_ttl(ir_ttl),
		.er_valid(er_valid), .er_leg(er_leg), .er_ipv6(er_ipv6), .er_len(er_len),
		.er_classifier_drop(er_classifier_drop),
		.er_route_enable_action(er_route_enable_action), .er_ucast_routed(er_ucast_routed),
		.er_mcast_routed(er_mcast_routed), .er_mcast_bridged(er_mcast_bridged),
		.er_mcast(er_mcast), .er_ttl(er_ttl));

	initial begin
		forever #25 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Holds the request until pready is sampled high; an edge always separates two calls
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			$display("unexpected at %0t: no pready", $time);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic select(input int g, input int idx, input int c);
		apb(1'b1, SEL_OFF, 32'((g << SEL_GRP_LSB) | (idx << SEL_IDX_LSB) | c));
	endtask : select

	// High part first so the low write loads both halves together
	task automatic set_counter(input int g, input int idx, input int c, input logic [39:0] v);
		select(g, idx, c);
		apb(1'b1, HIGH_OFF, {24'h0, v[39:32]});
		apb(1'b1, LOW_OFF, v[31:0]);
	endtask : set_counter

	task automatic get_counter(input int g, input int idx, input int c, output logic [39:0] v);
		logic [31:0] lo;
		select(g, idx, c);
		apb(1'b0, LOW_OFF, 32'h0);
		lo = rdat;
		apb(1'b0, HIGH_OFF, 32'h0);
		v = {rdat[7:0], lo};
	endtask : get_counter

	// Event k of group g, one frame; k selects which event flag is raised
	task automatic send(input int g, input int k, input int idx, input logic [LEN_W-1:0] len);
		@(posedge pclk);
		case (g)
			0: begin
				bcast_valid <= 1'b1;
				bcast_index <= PIDX_W'(idx);
				bcast_len <= len;
				bcast_kind <= (k == 6) ? 2'h3 : 2'(k % 3);
				bcast_discard <= (k < 3);
			end
			1: begin
				acl_valid <= 1'b1;
				acl_index <= PIDX_W'(idx);
				acl_len <= len;
				acl_cpu_src <= !k[0];
				acl_discard <= k[1];
				inner_policer_flag <= k[2];
			end
			2: begin
				ir_valid <= 1'b1;
				ir_leg <= LEG_W'(idx >> 1);
				ir_ipv6 <= idx[0];
				ir_len <= len;
				ir_classifier_drop <= (k == 0);
				ir_route_enable_action <= (k != 0);
				ir_ip_ucast <= (k == 1 || k == 6);
				ir_ip_mcast <= (k == 2);
				ir_ucast_routed <= (k == 3);
				ir_mcast_routed <= (k == 4);
				ir_rpf_fail <= (k == 5);
				ir_ttl <= (k == 6) ? 8'h01 : 8'h02;
			end
			default: begin
				er_valid <= 1'b1;
				er_leg <= LEG_W'(idx >> 1);
				er_ipv6 <= idx[0];
				er_len <= len;
				er_classifier_drop <= (k == 0);
				er_route_enable_action <= (k != 0);
				er_ucast_routed <= (k == 1);
				er_mcast_routed <= (k == 2);
				er_mcast_bridged <= (k == 3);
				er_mcast <= (k >= 2);
				er_ttl <= (k == 4) ? 8'h0f : 8'h10;
			end
		endcase
		@(posedge pclk);
		bcast_valid <= 1'b0;
		acl_valid <= 1'b0;
		ir_valid <= 1'b0;
		er_valid <= 1'b0;
	endtask : send

	// Mask bits hit by event k; a ttl drop is also a received unicast frame
	function automatic logic [7:0] hits(input int g, input int k);
		if (g == 0 && k == 6) return 8'h00;
		if (g == 2 && k == 6) return 8'h42;
		return 8'h01 << k;
	endfunction : hits

	function automatic logic [39:0] expect_sum(input int g, input int nev, input logic [7:0] m,
		input bit bytes);
		logic [39:0] s;
		s = '0;
		for (int k = 0; k < nev; k++) begin
			if ((hits(g, k) & m) != 8'h00) s += bytes ? 40'(1 << k) : 40'h1;
		end
		return s;
	endfunction : expect_sum

	// Lengths are distinct powers of two, so a byte count shows exactly which events hit
	task automatic run_group(input int g, input int idx, input int nev, input logic [7:0] m);
		int n;
		logic [39:0] v;
		logic [11:0] moff;
		n = (g < 2) ? 1 : 7;
		moff = (g == 0) ? BCAST_MASK_OFF : (g == 1) ? ACL_MASK_OFF :
			(g == 2) ? IR_MASK_OFF : ER_MASK_OFF;
		apb(1'b1, BCAST_CFG_OFF + 12'(4 * g), 32'h1);
		apb(1'b1, moff, {24'h0, m});
		apb(1'b1, moff + 12'(4 * n), 32'hff);
		if (g == 3) apb(1'b1, TTL_OFF + 12'(4 * (idx >> 1)), 32'h10);
		set_counter(g, idx, 0, 40'h0);
		set_counter(g, idx, n, 40'h0);
		for (int k = 0; k < nev; k++) send(g, k, idx, LEN_W'(1 << k));
		send(g, 0, idx ^ 1, 14'h3ff);
		get_counter(g, idx, 0, v);
		chk(v, expect_sum(g, nev, m, 1'b1));
		get_counter(g, idx, n, v);
		chk(v, expect_sum(g, nev, 8'hff, 1'b0));
		$display("test group %0d done", g);
	endtask : run_group

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		logic [39:0] v;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, SEL_OFF, 32'h0);
		chk(40'(rdat), 40'h0);
		apb(1'b0, IR_MASK_OFF, 32'h0);
		chk(40'(rdat), 40'h0);
		apb(1'b0, 12'h00c, 32'h0);
		chk({rdat, 7'h0, rerr}, 40'h1);
		$display("test reset and unmapped done");
		run_group(0, 5, 7, 8'h2b);
		run_group(1, 9, 8, 8'ha6);
		run_group(2, 11, 7, 8'h4a);
		run_group(3, 20, 5, 8'h15);
		set_counter(0, 5, 0, 40'h01_ffff_fff0);
		apb(1'b0, LOW_OFF, 32'h0);
		chk(40'(rdat), 40'hffff_fff0);
		send(0, 0, 5, 14'h20);
		apb(1'b0, HIGH_OFF, 32'h0);
		chk(40'(rdat), 40'h1);
		get_counter(0, 5, 0, v);
		chk(v, 40'h02_0000_0010);
		apb(1'b1, HIGH_OFF, 32'h33);
		get_counter(0, 5, 0, v);
		chk(v, 40'h02_0000_0010);
		apb(1'b1, LOW_OFF, 32'h7);
		get_counter(0, 5, 0, v);
		chk(v, 40'h33_0000_0007);
		set_counter(0, 5, 0, 40'hff_ffff_ffff);
		send(0, 0, 5, 14'h1);
		get_counter(0, 5, 0, v);
		chk(v, 40'h0);
		$display("test shadow and wrap done");
		close_out();
	end

	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		close_out();
	end
endmodule : prs_stat_counters_bench
